// ==== src/rfpg_defs.svh ====
// Constants of the scratch word file parity guard
`ifndef RFPG_DEFS_SVH
`define RFPG_DEFS_SVH

// ----------------------------------------------------------------------------
// File geometry
// ----------------------------------------------------------------------------
`define RFPG_DATA_W      27
`define RFPG_ADDR_W      6
`define RFPG_WORDS       64
`define RFPG_WORD_W      28
`define RFPG_PC_W        15

// ----------------------------------------------------------------------------
// Error code: leading octal digit and two octal address digits
// ----------------------------------------------------------------------------
`define RFPG_CODE_W      9
`define RFPG_CODE_LEAD   3'h7

// ----------------------------------------------------------------------------
// Register port offsets and fields
// ----------------------------------------------------------------------------
`define RFPG_REG_AW      8
`define RFPG_REG_CTRL    8'h00
`define RFPG_REG_STATUS  8'h04
`define RFPG_REG_COUNT   8'h08
`define RFPG_REG_SAVED   8'h0c
`define RFPG_CTRL_FORCE  0
`define RFPG_ST_SEEN     0
`define RFPG_ST_CHKEN    1
`define RFPG_ST_PEND     2
`define RFPG_ST_CODE_LO  8
`define RFPG_SV_CODE_LO  16
`define RFPG_CNT_W       16

// ----------------------------------------------------------------------------
// Buffer classes that can be aborted
// ----------------------------------------------------------------------------
`define RFPG_NCLS        3
`define RFPG_CLS_IO      0
`define RFPG_CLS_SM      1
`define RFPG_CLS_TYPE    2

`endif

// ==== src/rfpg_pkg.sv ====
// Types of the scratch word file parity guard
`include "rfpg_defs.svh"

package rfpg_pkg;

  // ----------------------------------------------------------------------------
  // Origin of a file access
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    RFPG_SRC_MOVE     = 3'b000,  // inter_register_move
    RFPG_SRC_FILEMODE = 3'b001,  // file_write_mode / file_read_mode
    RFPG_SRC_IO_ACT   = 3'b010,  // I/O activation
    RFPG_SRC_SM_ACT   = 3'b011,  // Search/move activation
    RFPG_SRC_IO_BUF   = 3'b100,  // I/O buffer cycle
    RFPG_SRC_SM_BUF   = 3'b101,  // Search/move buffer cycle
    RFPG_SRC_CLK_BUF  = 3'b110,  // Real-time clock buffer cycle
    RFPG_SRC_TYPE_BUF = 3'b111   // Typewriter buffer cycle
  } rfpg_src_type;

  // ----------------------------------------------------------------------------
  // Fault interrupt sequencer
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RFPG_IRQ_IDLE  = 2'b00,
    RFPG_IRQ_PEND  = 2'b01,
    RFPG_IRQ_ENTER = 2'b10
  } rfpg_irq_state_type;

endpackage

// ==== src/rfpg_par_if.sv ====
// Carrier between the guard and its parity units
`timescale 1ns/100ps
`include "rfpg_defs.svh"

interface rfpg_par_if;
  logic [`RFPG_DATA_W-1:0] data;     // Word under test
  logic                    par_in;   // Stored parity bit
  logic                    par_gen;  // Fresh odd parity
  logic                    par_ok;   // Word and stored parity agree

  modport unit (input data, input par_in, output par_gen, output par_ok);
  modport user (output data, output par_in, input par_gen, input par_ok);
endinterface

// ==== src/rfpg_parity_unit.sv ====
// Odd parity generator and checker for one file word
`timescale 1ns/100ps

module rfpg_parity_unit (
  rfpg_par_if.unit p  // Word in, parity out
);

  // ----------------------------------------------------------------------------
  // Odd parity: the word plus its parity bit holds an odd count of ones
  // ----------------------------------------------------------------------------
  assign p.par_gen = ~(^p.data);
  assign p.par_ok  = ^{p.data, p.par_in};

endmodule

// ==== src/rfpg_top.sv ====
// Scratch word file with parity generation, checking and fault handling
//
// Behaviour
// - Odd parity covers each 27-bit file word and is checked on fetch.
// - Every file write, from any source, stores freshly generated parity.
// - Every file read, from any source, has its parity checked.
// - Bad parity is never corrected; it stays until the word is rewritten.
// - A fault reports code seven followed by the failing file address.
// - A fault on a block control store request suppresses the memory write.
// - Buffer faults abort I/O, search/move or typewriter after current memory request.
// - Checking is active only while the halt or trap parity switch is on.
// - A fault raises an abnormal-class interrupt request with the trap switch on, and a halt request with the halt switch on.
// - On recognition save program counter and code, enter routine, re-execute instruction.
`timescale 1ns/100ps
`include "rfpg_defs.svh"

module rfpg_top
  import rfpg_pkg::*;
(
  input  wire logic                      clock_in,          // 20 MHz processor clock
  input  wire logic                      rst_in,            // Master clear, async, high
  input  wire logic                      halt_sw_in,        // Parity halt switch pin
  input  wire logic                      trap_sw_in,        // Parity trap switch pin
  input  wire logic                      wr_req_in,         // File write strobe
  input  wire rfpg_src_type              wr_src_in,         // Source of the write
  input  wire logic [`RFPG_ADDR_W-1:0]   wr_addr_in,        // File write address
  input  wire logic [`RFPG_DATA_W-1:0]   wr_data_in,        // File write word
  input  wire logic                      rd_req_in,         // File read strobe
  input  wire rfpg_src_type              rd_src_in,         // Source of the read
  input  wire logic [`RFPG_ADDR_W-1:0]   rd_addr_in,        // File read address
  input  wire logic                      rd_store_in,       // Read feeds a storage write
  output logic                           rd_valid_out,      // Read answer valid
  output logic [`RFPG_DATA_W-1:0]        rd_data_out,       // Read answer word
  output logic                           rd_err_out,        // Read answer failed parity
  output logic [`RFPG_CODE_W-1:0]        err_code_out,      // Code of last fault
  output logic                           mem_write_en_out,  // Storage write may proceed
  input  wire logic [`RFPG_NCLS-1:0]     mem_busy_in,       // Buffer memory request open
  output logic [`RFPG_NCLS-1:0]          abort_out,         // Buffer abort pulses
  input  wire logic [`RFPG_PC_W-1:0]     pc_in,             // Program counter now
  input  wire logic                      irq_ack_in,        // Interrupt recognised
  output logic                           abnormal_irq_out,  // Abnormal interrupt request
  output logic                           halt_req_out,      // Halt on fault request
  output logic                           enter_routine_out, // Enter routine pulse
  output logic [`RFPG_PC_W-1:0]          saved_pc_out,      // Saved resume address
  output logic [`RFPG_CODE_W-1:0]        saved_code_out,    // Saved interrupt code
  input  wire logic [`RFPG_REG_AW-1:0]   reg_addr_in,       // Register address
  input  wire logic [31:0]               reg_wdata_in,      // Register write data
  input  wire logic                      reg_wr_in,         // Register write strobe
  input  wire logic                      reg_rd_in,         // Register read strobe
  output logic [31:0]                    reg_rdata_out      // Register read data
);

  // ----------------------------------------------------------------------------
  // State of the whole block
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [`RFPG_WORDS-1:0][`RFPG_WORD_W-1:0] file;
    logic [1:0]                               halt_sync;
    logic [1:0]                               trap_sync;
    logic                                     rd_vld;
    logic [`RFPG_DATA_W-1:0]                  rd_data;
    logic                                     rd_err;
    logic                                     rd_store;
    logic [`RFPG_CODE_W-1:0]                  last_code;
    logic                                     err_seen;
    logic [`RFPG_CNT_W-1:0]                   err_count;
    logic                                     force_bad;
    logic [`RFPG_NCLS-1:0]                    abort_pend;
    logic [`RFPG_NCLS-1:0]                    abort;
    rfpg_irq_state_type                       irq_st;
    logic [`RFPG_CODE_W-1:0]                  pend_code;
    logic [`RFPG_PC_W-1:0]                    saved_pc;
    logic [`RFPG_CODE_W-1:0]                  saved_code;
    logic [31:0]                              rdata;
  } rfpg_state_type;

  rfpg_state_type q;
  rfpg_state_type d;

  // ----------------------------------------------------------------------------
  // Parity units on the write and read paths
  // ----------------------------------------------------------------------------
  rfpg_par_if wr_par ();
  rfpg_par_if rd_par ();

  rfpg_parity_unit u_wr_par (
    .p (wr_par.unit)
  );

  rfpg_parity_unit u_rd_par (
    .p (rd_par.unit)
  );

  logic [`RFPG_WORD_W-1:0] rd_word;  // Stored word at the read address
  logic                    chk_en;   // Checking switched on
  logic                    rd_fault; // Checked read found bad parity
  logic [`RFPG_CODE_W-1:0] rd_code;  // Code for the word being read
  logic [`RFPG_NCLS-1:0]   cls_hit;  // Buffer class of the read
  logic                    reg_seen_clr;

  // Drive the parity units
  assign rd_word       = q.file[rd_addr_in];
  assign wr_par.data   = wr_data_in;
  assign wr_par.par_in = 1'b0;                                 // Unused on the write path
  assign rd_par.data   = rd_word[`RFPG_DATA_W-1:0];
  assign rd_par.par_in = rd_word[`RFPG_WORD_W-1];

  // Checking follows the synchronised console switches
  assign chk_en = q.halt_sync[1] | q.trap_sync[1];

  // A fault only counts while checking is on
  assign rd_fault = rd_req_in & chk_en & ~rd_par.par_ok;

  // Lead digit seven then the six-bit address as two octal digits
  assign rd_code = {`RFPG_CODE_LEAD, rd_addr_in};

  // ----------------------------------------------------------------------------
  // Map the read source to the buffer activity it belongs to
  // ----------------------------------------------------------------------------
  always_comb begin
    cls_hit = '0;
    case (rd_src_in)
      RFPG_SRC_IO_BUF: begin
        cls_hit[`RFPG_CLS_IO] = 1'b1;
      end
      RFPG_SRC_SM_BUF: begin
        cls_hit[`RFPG_CLS_SM] = 1'b1;
      end
      RFPG_SRC_TYPE_BUF: begin
        cls_hit[`RFPG_CLS_TYPE] = 1'b1;
      end
      default: begin
        cls_hit = '0;
      end
    endcase
  end

  // Write-one-to-clear of the sticky fault flag
  assign reg_seen_clr = reg_wr_in & (reg_addr_in == `RFPG_REG_STATUS)
                        & reg_wdata_in[`RFPG_ST_SEEN];

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    d = q;

    // Switch pins pass two flip-flops before use
    d.halt_sync = {q.halt_sync[0], halt_sw_in};
    d.trap_sync = {q.trap_sync[0], trap_sw_in};

    // Every write stores fresh parity; forced inversion is a test aid
    if (wr_req_in) begin
      d.file[wr_addr_in] = {wr_par.par_gen ^ q.force_bad, wr_data_in};
    end

    // Read answer one cycle later; the stored word is returned unchanged
    d.rd_vld   = rd_req_in;
    d.rd_data  = rd_word[`RFPG_DATA_W-1:0];
    d.rd_err   = rd_fault;
    d.rd_store = rd_req_in & rd_store_in;
    if (rd_fault) begin
      d.last_code = rd_code;
    end

    // Sticky fault flag: a new fault wins over a clear
    if (reg_seen_clr) begin
      d.err_seen = 1'b0;
    end
    if (rd_fault) begin
      d.err_seen = 1'b1;
    end

    // Fault counter saturates; a write to it clears it, a fault wins
    if (reg_wr_in && reg_addr_in == `RFPG_REG_COUNT) begin
      d.err_count = '0;
    end
    if (rd_fault && q.err_count != {`RFPG_CNT_W{1'b1}}) begin
      d.err_count = q.err_count + `RFPG_CNT_W'(1);
    end

    // Control register
    if (reg_wr_in && reg_addr_in == `RFPG_REG_CTRL) begin
      d.force_bad = reg_wdata_in[`RFPG_CTRL_FORCE];
    end

    // Buffer abort waits until the open memory request ends
    d.abort      = q.abort_pend & ~mem_busy_in;
    d.abort_pend = (q.abort_pend & mem_busy_in)
                   | (cls_hit & {`RFPG_NCLS{rd_fault}});

    // Fault interrupt sequencer
    case (q.irq_st)
      RFPG_IRQ_IDLE: begin
        if (rd_fault) begin
          d.pend_code = rd_code;
          d.irq_st    = RFPG_IRQ_PEND;
        end
      end
      RFPG_IRQ_PEND: begin
        if (irq_ack_in) begin
          d.saved_pc   = pc_in;
          d.saved_code = q.pend_code;
          d.irq_st     = RFPG_IRQ_ENTER;
        end
      end
      RFPG_IRQ_ENTER: begin
        d.irq_st = RFPG_IRQ_IDLE;
      end
      default: begin
        d.irq_st = RFPG_IRQ_IDLE;
      end
    endcase

    // Register read data stand in the cycle after the strobe only
    d.rdata = '0;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `RFPG_REG_CTRL: begin
          d.rdata[`RFPG_CTRL_FORCE] = q.force_bad;
        end
        `RFPG_REG_STATUS: begin
          d.rdata[`RFPG_ST_SEEN]  = q.err_seen;
          d.rdata[`RFPG_ST_CHKEN] = chk_en;
          d.rdata[`RFPG_ST_PEND]  = (q.irq_st == RFPG_IRQ_PEND);
          d.rdata[`RFPG_ST_CODE_LO +: `RFPG_CODE_W] = q.last_code;
        end
        `RFPG_REG_COUNT: begin
          d.rdata[`RFPG_CNT_W-1:0] = q.err_count;
        end
        `RFPG_REG_SAVED: begin
          d.rdata[`RFPG_PC_W-1:0] = q.saved_pc;
          d.rdata[`RFPG_SV_CODE_LO +: `RFPG_CODE_W] = q.saved_code;
        end
        default: begin
          d.rdata = '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign rd_valid_out      = q.rd_vld;
  assign rd_data_out       = q.rd_data;
  assign rd_err_out        = q.rd_err;
  assign err_code_out      = q.last_code;
  assign mem_write_en_out  = q.rd_vld & q.rd_store & ~q.rd_err;
  assign abort_out         = q.abort;
  assign abnormal_irq_out  = (q.irq_st == RFPG_IRQ_PEND) & q.trap_sync[1];
  assign halt_req_out      = (q.irq_st == RFPG_IRQ_PEND) & q.halt_sync[1];
  assign enter_routine_out = (q.irq_st == RFPG_IRQ_ENTER);
  assign saved_pc_out      = q.saved_pc;
  assign saved_code_out    = q.saved_code;
  assign reg_rdata_out     = q.rdata;

endmodule

// ==== verif/rfpg_props.sv ====
// Property checker bound to the parity guard top
`timescale 1ns/100ps
`include "rfpg_defs.svh"

module rfpg_props (
  input wire logic        clock_in,          // Clock
  input wire logic        rst_in,            // Reset
  input wire logic        halt_sw_in,        // Halt switch
  input wire logic        trap_sw_in,        // Trap switch
  input wire logic        rd_req_in,         // Read strobe
  input wire logic [5:0]  rd_addr_in,        // Read address
  input wire logic        rd_store_in,       // Store request
  input wire logic        rd_valid_out,      // Read answer
  input wire logic        rd_err_out,        // Read fault
  input wire logic [8:0]  err_code_out,      // Fault code
  input wire logic        mem_write_en_out,  // Store enable
  input wire logic [2:0]  mem_busy_in,       // Open requests
  input wire logic [2:0]  abort_out,         // Abort pulses
  input wire logic [14:0] pc_in,             // Program counter
  input wire logic        irq_ack_in,        // Recognition
  input wire logic        abnormal_irq_out,  // Interrupt
  input wire logic        enter_routine_out, // Entry pulse
  input wire logic [14:0] saved_pc_out       // Saved counter
);
  // ------------
  // Properties
  // ------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  AST_RD_ANSWER: assert property (rd_req_in |=> rd_valid_out)
    else $error("read answer missing");
  AST_ERR_CODE: assert property (rd_err_out |-> err_code_out == {3'h7, $past(rd_addr_in)})
    else $error("fault code wrong");
  AST_STORE_BLOCK: assert property (mem_write_en_out == (rd_valid_out && $past(rd_store_in) && !rd_err_out))
    else $error("store enable wrong");
  AST_CHK_OFF: assert property ((!halt_sw_in && !trap_sw_in)[*4] ##0 rd_req_in |=> !rd_err_out)
    else $error("fault with checking off");
  AST_NO_TRAP: assert property (!trap_sw_in[*4] |-> !abnormal_irq_out)
    else $error("interrupt without trap switch");
  AST_ENTER: assert property (abnormal_irq_out && irq_ack_in |=> enter_routine_out ##1 !enter_routine_out)
    else $error("routine entry wrong");
  AST_SAVE_PC: assert property (abnormal_irq_out && irq_ack_in |=> saved_pc_out == $past(pc_in))
    else $error("saved counter wrong");
  AST_ABORT_WAIT: assert property (abort_out != 3'h0 |-> (abort_out & $past(mem_busy_in)) == 3'h0)
    else $error("abort during open request");
  AST_ABORT_PULSE: assert property (abort_out != 3'h0 |=> (abort_out & $past(abort_out)) == 3'h0)
    else $error("abort longer than one cycle");

  // Main scenarios reached
  cover property (rd_err_out);
  cover property (enter_routine_out);
  cover property (abort_out != 3'h0);
endmodule

bind rfpg_top rfpg_props u_props (.clock_in, .rst_in, .halt_sw_in, .trap_sw_in, .rd_req_in,
  .rd_addr_in, .rd_store_in, .rd_valid_out, .rd_err_out, .err_code_out, .mem_write_en_out,
  .mem_busy_in, .abort_out, .pc_in, .irq_ack_in, .abnormal_irq_out, .enter_routine_out,
  .saved_pc_out);

// ==== verif/rfpg_far_model.sv ====
// Far-side model: buffer memory requests and interrupt recognition
`timescale 1ns/100ps

module rfpg_far_model (
  input  wire logic       clock_in,    // Clock
  input  wire logic       rst_in,      // Reset
  input  wire logic       irq_in,      // Request level
  input  wire logic [3:0] ack_dly_in,  // Recognition delay
  input  wire logic [2:0] busy_go_in,  // Open a request
  input  wire logic [3:0] busy_len_in, // Request length
  output logic      [2:0] busy_out,    // Request open
  output logic            ack_out      // Recognised
);
  logic [3:0]      wait_q;
  logic [2:0][3:0] len_q;

  // Recognise after a delay; count down open memory requests
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wait_q <= 4'h0;
      ack_out <= 1'b0;
      len_q <= '0;
    end else begin
      ack_out <= irq_in && !ack_out && wait_q >= ack_dly_in;
      wait_q <= irq_in ? wait_q + 4'h1 : 4'h0;
      for (int k = 0; k < 3; k++) begin
        if (busy_go_in[k]) len_q[k] <= busy_len_in;
        else if (len_q[k] != 4'h0) len_q[k] <= len_q[k] - 4'h1;
      end
    end
  end

  // Open while the count runs
  always_comb begin
    for (int k = 0; k < 3; k++) busy_out[k] = len_q[k] != 4'h0;
  end
endmodule

// ==== verif/tb_register_file_parity_guard.sv ====
// Self-checking bench for the scratch word file parity guard
`timescale 1ns/100ps
`include "rfpg_defs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end

module tb_register_file_parity_guard
  import rfpg_pkg::*;
;
  logic         clock_in = 0, rst_in = 1, halt_sw_in = 0, trap_sw_in = 1;
  logic         wr_req_in = 0, rd_req_in = 0, rd_store_in = 0, irq_ack_in;
  logic         reg_wr_in = 0, reg_rd_in = 0, rd_valid_out, rd_err_out, mem_write_en_out;
  logic         abnormal_irq_out, halt_req_out, enter_routine_out;
  rfpg_src_type wr_src_in = RFPG_SRC_MOVE, rd_src_in = RFPG_SRC_MOVE;
  logic [5:0]   wr_addr_in = '0, rd_addr_in = '0;
  logic [26:0]  wr_data_in = '0, rd_data_out;
  logic [2:0]   mem_busy_in, abort_out, busy_go = '0;
  logic [14:0]  pc_in = '0, saved_pc_out;
  logic [8:0]   err_code_out, saved_code_out;
  logic [7:0]   reg_addr_in = '0;
  logic [31:0]  reg_wdata_in = '0, reg_rdata_out;
  logic [3:0]   dly = 4'h2;
  logic [26:0]  shadow [64];
  logic         bad_q [64];
  rfpg_src_type cls [3] = '{RFPG_SRC_IO_BUF, RFPG_SRC_SM_BUF, RFPG_SRC_TYPE_BUF};
  int           bad_count = 0, checked = 0;

  rfpg_top dut (.*);
  rfpg_far_model far (.clock_in, .rst_in, .irq_in(abnormal_irq_out | halt_req_out),
    .ack_dly_in(dly), .busy_go_in(busy_go), .busy_len_in(4'h5), .busy_out(mem_busy_in),
    .ack_out(irq_ack_in));

  always #25 clock_in = ~clock_in;

  // ------------
  // Expectations and bus tasks
  // ------------
  function automatic logic [8:0] code(input logic [5:0] a);
    return {`RFPG_CODE_LEAD, a};
  endfunction

  task automatic wr(input logic [5:0] a, input logic [26:0] d, input logic bad);
    @(posedge clock_in);
    wr_req_in <= 1'b1;
    wr_addr_in <= a;
    wr_data_in <= d;
    wr_src_in <= rfpg_src_type'(3'($urandom));
    @(posedge clock_in);
    wr_req_in <= 1'b0;
    shadow[a] = d;
    bad_q[a] = bad;
  endtask

  task automatic rd(input logic [5:0] a, input rfpg_src_type s, input logic st,
                    input logic chk, input logic [2:0] bg);
    logic e;
    e = chk && bad_q[a];
    @(posedge clock_in);
    rd_req_in <= 1'b1;
    rd_addr_in <= a;
    rd_src_in <= s;
    rd_store_in <= st;
    busy_go <= bg;
    @(posedge clock_in);
    rd_req_in <= 1'b0;
    busy_go <= 3'h0;
    @(negedge clock_in);
    `CHK(rd_valid_out, 1'b1)
    `CHK(rd_data_out, shadow[a])
    `CHK(rd_err_out, e)
    `CHK(mem_write_en_out, st && !e)
    if (e) `CHK(err_code_out, code(a))
  endtask

  task automatic rg(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clock_in);
    reg_wr_in <= w;
    reg_rd_in <= !w;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    @(negedge clock_in);
    q = reg_rdata_out;
  endtask

  task automatic finish_test;
    if (bad_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge clock_in);
    bad_count++;
    finish_test();
  end

  // ------------
  // Scenarios
  // ------------
  initial begin
    logic [31:0] q;
    logic [5:0]  a;
    void'($urandom(76739));
    for (int i = 0; i < 64; i++) begin
      shadow[i] = '0;
      bad_q[i] = 1'b1;
    end
    repeat (8) @(posedge clock_in);
    rst_in <= 1'b0;
    pc_in <= 15'($urandom);
    dly <= 4'($urandom_range(9));
    repeat (3) @(posedge clock_in);
    // Unwritten word faults, interrupt saves counter and code
    rd(6'h05, RFPG_SRC_MOVE, 1'b1, 1'b1, 3'h0);
    `CHK(abnormal_irq_out, 1'b1)
    for (int n = 0; n < 20 && !enter_routine_out; n++) @(negedge clock_in);
    `CHK(enter_routine_out, 1'b1)
    `CHK(saved_pc_out, pc_in)
    `CHK(saved_code_out, code(6'h05))
    rg(1'b0, 8'h0c, 32'h0, q);
    `CHK(q, {7'h0, code(6'h05), 1'b0, pc_in})
    // Random words come back unchanged, corner word first
    for (int i = 0; i < 40; i++) begin
      a = (i == 0) ? 6'h00 : 6'($urandom);
      wr(a, (i == 0) ? 27'h7ffffff : 27'($urandom), 1'b0);
      rd(a, rfpg_src_type'(3'($urandom)), 1'($urandom), 1'b1, 3'h0);
      `CHK(rd_err_out, 1'b0)
    end
    // Forced bad parity stays until the word is rewritten
    rg(1'b1, 8'h00, 32'h1, q);
    wr(6'h3f, 27'h5a5a5a5, 1'b1);
    for (int k = 0; k < 3; k++) wr(6'h20 + 6'(k), 27'(k), 1'b1);
    rg(1'b1, 8'h00, 32'h0, q);
    rd(6'h3f, RFPG_SRC_MOVE, 1'b1, 1'b1, 3'h0);
    rd(6'h3f, RFPG_SRC_FILEMODE, 1'b1, 1'b1, 3'h0);
    wr(6'h3f, 27'h5a5a5a5, 1'b0);
    rd(6'h3f, RFPG_SRC_MOVE, 1'b1, 1'b1, 3'h0);
    // Buffer faults abort only after the open memory request ends
    for (int k = 0; k < 3; k++) begin
      rd(6'h20 + 6'(k), cls[k], 1'b0, 1'b1, 3'(1 << k));
      for (int n = 0; n < 20 && mem_busy_in[k]; n++) begin
        `CHK(abort_out, 3'h0)
        @(negedge clock_in);
      end
      `CHK(abort_out, 3'h0)
      @(negedge clock_in);
      `CHK(abort_out, 3'(1 << k))
    end
    // Let the fault sequencer go idle first, else a pending fault is stranded
    for (int n = 0; n < 30 && (abnormal_irq_out || enter_routine_out); n++)
      @(negedge clock_in);
    `CHK(abnormal_irq_out | enter_routine_out, 1'b0)
    // Both switches off: no faults, status shows checking off
    @(posedge clock_in);
    trap_sw_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    rd(6'h20, RFPG_SRC_MOVE, 1'b1, 1'b0, 3'h0);
    rg(1'b0, 8'h04, 32'h0, q);
    `CHK(q[1], 1'b0)
    rg(1'b0, 8'h10, 32'h0, q);
    `CHK(q, 32'h0)
    // Halt switch alone checks and requests a halt, no interrupt
    @(posedge clock_in);
    halt_sw_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    rd(6'h21, RFPG_SRC_MOVE, 1'b0, 1'b1, 3'h0);
    `CHK(halt_req_out, 1'b1)
    `CHK(abnormal_irq_out, 1'b0)
    finish_test();
  end
endmodule
